// ### hdl/gsr_pkg.sv
// Shared constants, register map and carrier types for the group service request decoder
package gsr_pkg;
  // Sizes
  localparam int unsigned NUM_GROUPS = 8;                 // Channel groups served
  localparam int unsigned NUM_CHANS  = 32;                // Channels per group and direction
  localparam int unsigned ADDR_W     = 8;                 // APB address width
  localparam int unsigned IRQ_W      = NUM_GROUPS + 1;    // Ack per group plus chip reset done

  // Register byte offsets
  localparam logic [7:0] OFS_CMD_BASE   = 8'h00;          // group_command_request, one word per group
  localparam logic [7:0] OFS_CMD_LAST   = 8'h1C;
  localparam logic [7:0] OFS_INT_STATUS = 8'h20;          // RO sticky events
  localparam logic [7:0] OFS_INT_CLEAR  = 8'h24;          // WO, ones clear
  localparam logic [7:0] OFS_INT_ENABLE = 8'h28;          // RW
  localparam logic [7:0] OFS_PORT_MAP   = 8'h2C;          // RW port_to_group_map
  localparam logic [7:0] OFS_STATE      = 8'h30;          // RO pending and busy

  // Request word fields
  localparam int unsigned CODE_LSB = 8;                   // service_code at 12:8
  localparam int unsigned CODE_MSB = 12;
  localparam int unsigned DIR_BIT  = 7;                   // 1 = receive
  localparam int unsigned CHAN_LSB = 0;                   // Channel number 4:0
  localparam int unsigned CHAN_MSB = 4;
  localparam int unsigned BUSY_BIT = 8;                   // In the state register
  localparam int unsigned CHIP_IRQ_BIT = NUM_GROUPS;      // Chip reset done event

  // Service codes
  localparam logic [4:0] SC_NOP      = 5'h00;
  localparam logic [4:0] SC_CHIP_RST = 5'h01;
  localparam logic [4:0] SC_GRP_RST  = 5'h02;
  localparam logic [4:0] SC_GLB_INIT = 5'h04;
  localparam logic [4:0] SC_GRP_INIT = 5'h05;
  localparam logic [4:0] SC_CH_ACT   = 5'h08;
  localparam logic [4:0] SC_CH_DEACT = 5'h09;
  localparam logic [4:0] SC_CH_JUMP  = 5'h0A;
  localparam logic [4:0] SC_CH_CFG   = 5'h0B;
  localparam logic [4:0] SC_RD_GLB   = 5'h10;
  localparam logic [4:0] SC_RD_IQ    = 5'h11;
  localparam logic [4:0] SC_RD_GRP   = 5'h12;
  localparam logic [4:0] SC_RD_MPROT = 5'h13;
  localparam logic [4:0] SC_RD_MLEN  = 5'h14;
  localparam logic [4:0] SC_RD_PORT  = 5'h15;

  // Descriptor kinds fetched from shared memory, ordered so ranges walk in sequence
  localparam logic [3:0] FK_GLOBAL  = 4'h0;
  localparam logic [3:0] FK_IQ      = 4'h1;
  localparam logic [3:0] FK_TSMAP   = 4'h2;
  localparam logic [3:0] FK_SUBMAP  = 4'h3;
  localparam logic [3:0] FK_CHCFG   = 4'h4;
  localparam logic [3:0] FK_GRPCFG  = 4'h5;
  localparam logic [3:0] FK_MEMPROT = 4'h6;
  localparam logic [3:0] FK_MSGLEN  = 4'h7;
  localparam logic [3:0] FK_PORTCFG = 4'h8;
  localparam logic [3:0] FK_HEAD    = 4'h9;
  localparam logic [3:0] FK_STEP    = 4'h1;

  // Descriptor fetch request to the DMA logic
  typedef struct packed {
    logic [3:0] kind;   // Which descriptor
    logic [2:0] group;  // Channel group
    logic       dir;    // 1 = receive
    logic [4:0] chan;   // Channel for per-channel kinds
  } gsr_fetch_t;

  // request_ack_descriptor sent to the host interrupt queue
  typedef struct packed {
    logic [2:0] group;  // Group ID of the answered request
    logic [4:0] code;   // Service code answered
    logic       dir;
    logic [4:0] chan;
  } gsr_ack_t;

  // Readable registers handed to the bus slave
  typedef struct packed {
    logic [IRQ_W-1:0]      int_status;
    logic [IRQ_W-1:0]      int_enable;
    logic [1:0]            port_map;
    logic [NUM_GROUPS-1:0] pending;
    logic                  busy;
  } gsr_rdregs_t;

  // Decoded register write from the bus slave
  typedef struct packed {
    logic        valid;
    logic [7:0]  addr;
    logic [31:0] data;
  } gsr_wr_t;
endpackage

// ### hdl/gsr_apb.sv
// APB slave front end: one wait state, write strobes out, read mux in
`timescale 1ns/1ps
module gsr_apb (
  // Clock and reset
  input  wire logic                      clk_i,
  input  wire logic                      rstn_i,
  // APB
  input  wire logic                      psel_i,
  input  wire logic                      penable_i,
  input  wire logic                      pwrite_i,
  input  wire logic [gsr_pkg::ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]               pwdata_i,
  output logic                           pready_o,
  output logic [31:0]                    prdata_o,
  output logic                           pslverr_o,
  // Register side
  input  gsr_pkg::gsr_rdregs_t           rd_i,
  output gsr_pkg::gsr_wr_t               wr_o
);
  // All slave state
  typedef struct packed {
    logic             pready;
    logic [31:0]      prdata;
    logic             pslverr;
    gsr_pkg::gsr_wr_t wr;
  } gsr_apb_st_t;

  gsr_apb_st_t st;       // Registered state
  gsr_apb_st_t next_st;  // Next state
  logic        mapped;   // Address hits a register
  logic [31:0] rdata;    // Read mux result

  // Address decode and read mux; write-only words read as zero
  always_comb begin
    mapped = 1'b1;
    rdata  = 32'h0000_0000;
    if (paddr_i <= gsr_pkg::OFS_CMD_LAST && paddr_i[1:0] == 2'h0) begin
      rdata = 32'h0000_0000;
    end else begin
      case (paddr_i)
        gsr_pkg::OFS_INT_STATUS: rdata = 32'(rd_i.int_status);
        gsr_pkg::OFS_INT_CLEAR:  rdata = 32'h0000_0000;
        gsr_pkg::OFS_INT_ENABLE: rdata = 32'(rd_i.int_enable);
        gsr_pkg::OFS_PORT_MAP:   rdata = 32'(rd_i.port_map);
        gsr_pkg::OFS_STATE:      rdata = 32'({rd_i.busy, rd_i.pending});
        default:                 mapped = 1'b0;
      endcase
    end
  end

  // Answer in the cycle after the access phase starts; the strobe lines up with pready
  always_comb begin
    next_st          = st;
    next_st.pready   = 1'b0;
    next_st.wr.valid = 1'b0;
    // Error flag stands only beside its pready pulse
    next_st.pslverr  = 1'b0;
    if (psel_i && penable_i && !st.pready) begin
      next_st.pready   = 1'b1;
      next_st.pslverr  = !mapped;
      next_st.prdata   = (pwrite_i || !mapped) ? 32'h0000_0000 : rdata;
      // Unmapped writes are dropped so no register is touched by a stray address
      next_st.wr.valid = pwrite_i && mapped;
      next_st.wr.addr  = paddr_i;
      next_st.wr.data  = pwdata_i;
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign pready_o  = st.pready;
  assign prdata_o  = st.prdata;
  assign pslverr_o = st.pslverr;
  assign wr_o      = st.wr;
endmodule

// ### hdl/gsr_irq.sv
// Sticky interrupt status with enable and write-one-to-clear
`timescale 1ns/1ps
module gsr_irq (
  // Clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     rstn_i,
  // Events and software access
  input  wire logic [gsr_pkg::IRQ_W-1:0] set_i,
  input  gsr_pkg::gsr_wr_t              wr_i,
  // Results
  output logic [gsr_pkg::IRQ_W-1:0]     status_o,
  output logic [gsr_pkg::IRQ_W-1:0]     enable_o,
  output logic                          irq_o
);
  // All interrupt state
  typedef struct packed {
    logic [gsr_pkg::IRQ_W-1:0] status;
    logic [gsr_pkg::IRQ_W-1:0] enable;
    logic                      irq;
  } gsr_irq_st_t;

  gsr_irq_st_t st;       // Registered state
  gsr_irq_st_t next_st;  // Next state

  // A new event beats a clear landing in the same cycle
  always_comb begin
    next_st = st;
    if (wr_i.valid && wr_i.addr == gsr_pkg::OFS_INT_CLEAR) begin
      next_st.status = st.status & ~wr_i.data[gsr_pkg::IRQ_W-1:0];
    end
    if (wr_i.valid && wr_i.addr == gsr_pkg::OFS_INT_ENABLE) begin
      next_st.enable = wr_i.data[gsr_pkg::IRQ_W-1:0];
    end
    next_st.status = next_st.status | set_i;
    next_st.irq    = |(next_st.status & next_st.enable);
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign status_o = st.status;
  assign enable_o = st.enable;
  assign irq_o    = st.irq;
endmodule

// ### hdl/gsr_decoder.sv
// Per-group service request registers and the request decoder and sequencer
`timescale 1ns/1ps
module gsr_decoder (
  // Clock and reset
  input  wire logic                                clk_i,
  input  wire logic                                rstn_i,
  // APB slave
  input  wire logic                                psel_i,
  input  wire logic                                penable_i,
  input  wire logic                                pwrite_i,
  input  wire logic [gsr_pkg::ADDR_W-1:0]           paddr_i,
  input  wire logic [31:0]                         pwdata_i,
  output logic                                     pready_o,
  output logic [31:0]                              prdata_o,
  output logic                                     pslverr_o,
  // Descriptor fetch to the DMA logic
  output logic                                     fetch_valid_o,
  output gsr_pkg::gsr_fetch_t                      fetch_o,
  input  wire logic                                fetch_done_i,
  // Acknowledge descriptor to the interrupt queue writer
  output logic                                     ack_valid_o,
  output gsr_pkg::gsr_ack_t                        ack_o,
  input  wire logic                                ack_ready_i,
  // Device state driven to the group processors
  output logic [1:0]                               port_to_group_map_o,
  output logic [gsr_pkg::NUM_GROUPS-1:0]           port_en_tx_o,
  output logic [gsr_pkg::NUM_GROUPS-1:0]           port_en_rx_o,
  output logic [gsr_pkg::NUM_GROUPS*gsr_pkg::NUM_CHANS-1:0] chan_act_tx_o,
  output logic [gsr_pkg::NUM_GROUPS*gsr_pkg::NUM_CHANS-1:0] chan_act_rx_o,
  output logic                                     iq_rewind_o,
  // Interrupt
  output logic                                     irq_o
);
  localparam int unsigned NG = gsr_pkg::NUM_GROUPS;
  localparam int unsigned NC = gsr_pkg::NUM_CHANS;

  // Sequencer phases
  typedef enum logic [1:0] {
    GSR_IDLE,
    GSR_FETCH,
    GSR_ACK
  } gsr_phase_t;

  // One held request slot per group
  typedef struct packed {
    logic [4:0] code;
    logic       dir;
    logic [4:0] chan;
  } gsr_slot_t;

  // All decoder state
  typedef struct packed {
    logic [NG-1:0]          pending;     // Slot holds an unserved request
    gsr_slot_t [NG-1:0]     slot;        // Latched request words
    gsr_phase_t             phase;
    logic [2:0]             cur_group;   // Group being served
    gsr_slot_t              cur;         // Request being served
    logic [3:0]             last_kind;   // Final descriptor of the fetch run
    logic                   fetch_valid;
    gsr_pkg::gsr_fetch_t    fetch;
    logic                   ack_valid;
    gsr_pkg::gsr_ack_t      ack;
    logic [1:0]             port_map;
    logic [NG-1:0]          port_tx;
    logic [NG-1:0]          port_rx;
    logic [NG*NC-1:0]       act_tx;
    logic [NG*NC-1:0]       act_rx;
    logic                   iq_rewind;   // One-cycle pulse
    logic [gsr_pkg::IRQ_W-1:0] irq_set;  // One-cycle event pulses
  } gsr_dec_st_t;

  gsr_dec_st_t          st;        // Registered state
  gsr_dec_st_t          next_st;   // Next state
  gsr_pkg::gsr_wr_t     wr;        // Register write strobe from the bus slave
  gsr_pkg::gsr_rdregs_t rd;        // Readable registers
  logic [gsr_pkg::IRQ_W-1:0] int_status;
  logic [gsr_pkg::IRQ_W-1:0] int_enable;
  logic [NG-1:0]        cmd_wr;    // Per-group command write hit
  logic                 chip_rst;  // Chip reset request written this cycle

  // Bus slave
  gsr_apb u_apb (
    .clk_i     (clk_i),
    .rstn_i    (rstn_i),
    .psel_i    (psel_i),
    .penable_i (penable_i),
    .pwrite_i  (pwrite_i),
    .paddr_i   (paddr_i),
    .pwdata_i  (pwdata_i),
    .pready_o  (pready_o),
    .prdata_o  (prdata_o),
    .pslverr_o (pslverr_o),
    .rd_i      (rd),
    .wr_o      (wr)
  );

  // Interrupt status, enable and clear
  gsr_irq u_irq (
    .clk_i    (clk_i),
    .rstn_i   (rstn_i),
    .set_i    (st.irq_set),
    .wr_i     (wr),
    .status_o (int_status),
    .enable_o (int_enable),
    .irq_o    (irq_o)
  );

  // Readable register view
  always_comb begin
    rd.int_status = int_status;
    rd.int_enable = int_enable;
    rd.port_map   = st.port_map;
    rd.pending    = st.pending;
    rd.busy       = (st.phase != GSR_IDLE);
  end

  // Command register decode, one word per group
  genvar g;
  generate
    for (g = 0; g < NG; g++) begin : g_cmd
      assign cmd_wr[g] = wr.valid && (wr.addr == gsr_pkg::OFS_CMD_BASE + 8'(4 * g));
    end
  endgenerate

  // Bits above the code field are ignored, so stray high bits cannot alias a code
  assign chip_rst = (|cmd_wr) &&
                    (wr.data[gsr_pkg::CODE_MSB:gsr_pkg::CODE_LSB] == gsr_pkg::SC_CHIP_RST);

  // Decoder and sequencer
  always_comb begin
    logic       found;
    logic [2:0] pick;
    gsr_slot_t  req;
    logic       need_fetch;
    logic [3:0] first_kind;
    logic [3:0] end_kind;
    found      = 1'b0;
    pick       = 3'h0;
    req        = '0;
    need_fetch = 1'b0;
    first_kind = gsr_pkg::FK_GLOBAL;
    end_kind   = gsr_pkg::FK_GLOBAL;
    next_st    = st;
    next_st.iq_rewind = 1'b0;
    next_st.irq_set   = '0;

    // Latch new requests; a second write to a busy group simply replaces the word
    for (int i = 0; i < NG; i++) begin
      if (cmd_wr[i]) begin
        next_st.pending[i]   = 1'b1;
        next_st.slot[i].code = wr.data[gsr_pkg::CODE_MSB:gsr_pkg::CODE_LSB];
        next_st.slot[i].dir  = wr.data[gsr_pkg::DIR_BIT];
        next_st.slot[i].chan = wr.data[gsr_pkg::CHAN_MSB:gsr_pkg::CHAN_LSB];
      end
    end

    case (st.phase)
      // Serve the lowest pending group
      GSR_IDLE: begin
        for (int i = NG - 1; i >= 0; i--) begin
          if (st.pending[i]) begin
            found = 1'b1;
            pick  = 3'(i);
          end
        end
        if (found) begin
          req = st.slot[pick];
          if (!cmd_wr[pick]) begin
            next_st.pending[pick] = 1'b0;
          end
          next_st.cur_group = pick;
          next_st.cur       = req;
          case (req.code)
            gsr_pkg::SC_GRP_RST: begin
              next_st.port_tx[pick] = 1'b0;
              next_st.port_rx[pick] = 1'b0;
              next_st.act_tx[pick*NC +: NC] = '0;
              next_st.act_rx[pick*NC +: NC] = '0;
            end
            gsr_pkg::SC_GLB_INIT: begin
              need_fetch = 1'b1;
              first_kind = gsr_pkg::FK_GLOBAL;
              end_kind   = gsr_pkg::FK_IQ;
              next_st.iq_rewind = 1'b1;
            end
            gsr_pkg::SC_GRP_INIT: begin
              need_fetch = 1'b1;
              first_kind = gsr_pkg::FK_TSMAP;
              end_kind   = gsr_pkg::FK_PORTCFG;
            end
            gsr_pkg::SC_CH_ACT, gsr_pkg::SC_CH_JUMP: begin
              // Activation restarts the channel from its head pointer
              if (req.dir) begin
                next_st.act_rx[pick*NC + int'(req.chan)] = 1'b1;
              end else begin
                next_st.act_tx[pick*NC + int'(req.chan)] = 1'b1;
              end
              need_fetch = 1'b1;
              first_kind = gsr_pkg::FK_HEAD;
              end_kind   = gsr_pkg::FK_HEAD;
            end
            gsr_pkg::SC_CH_DEACT: begin
              if (req.dir) begin
                next_st.act_rx[pick*NC + int'(req.chan)] = 1'b0;
              end else begin
                next_st.act_tx[pick*NC + int'(req.chan)] = 1'b0;
              end
            end
            gsr_pkg::SC_CH_CFG: begin
              need_fetch = 1'b1;
              first_kind = gsr_pkg::FK_CHCFG;
              end_kind   = gsr_pkg::FK_CHCFG;
            end
            gsr_pkg::SC_RD_GLB, gsr_pkg::SC_RD_GRP, gsr_pkg::SC_RD_MPROT,
            gsr_pkg::SC_RD_MLEN, gsr_pkg::SC_RD_PORT: begin
              need_fetch = 1'b1;
              case (req.code)
                gsr_pkg::SC_RD_GLB:   first_kind = gsr_pkg::FK_GLOBAL;
                gsr_pkg::SC_RD_GRP:   first_kind = gsr_pkg::FK_GRPCFG;
                gsr_pkg::SC_RD_MPROT: first_kind = gsr_pkg::FK_MEMPROT;
                gsr_pkg::SC_RD_MLEN:  first_kind = gsr_pkg::FK_MSGLEN;
                default:              first_kind = gsr_pkg::FK_PORTCFG;
              endcase
              end_kind = first_kind;
            end
            gsr_pkg::SC_RD_IQ: begin
              need_fetch = 1'b1;
              first_kind = gsr_pkg::FK_IQ;
              end_kind   = gsr_pkg::FK_IQ;
              next_st.iq_rewind = 1'b1;
            end
            // No-op and reserved codes leave state alone and go straight to the answer
            default: begin
              need_fetch = 1'b0;
            end
          endcase
          if (need_fetch) begin
            next_st.phase       = GSR_FETCH;
            next_st.fetch_valid = 1'b1;
            next_st.fetch.kind  = first_kind;
            next_st.fetch.group = pick;
            next_st.fetch.dir   = req.dir;
            next_st.fetch.chan  = req.chan;
            next_st.last_kind   = end_kind;
          end else begin
            next_st.phase     = GSR_ACK;
            next_st.ack_valid = 1'b1;
            next_st.ack       = '{group: pick, code: req.code, dir: req.dir, chan: req.chan};
          end
        end
      end
      // Walk the descriptor run, one fetch at a time
      GSR_FETCH: begin
        if (fetch_done_i) begin
          // A fresh port configuration turns the group's port on in that direction
          if (st.fetch.kind == gsr_pkg::FK_PORTCFG) begin
            if (st.cur.dir) begin
              next_st.port_rx[st.cur_group] = 1'b1;
            end else begin
              next_st.port_tx[st.cur_group] = 1'b1;
            end
          end
          if (st.fetch.kind == st.last_kind) begin
            next_st.fetch_valid = 1'b0;
            next_st.phase       = GSR_ACK;
            next_st.ack_valid   = 1'b1;
            next_st.ack         = '{group: st.cur_group, code: st.cur.code, dir: st.cur.dir, chan: st.cur.chan};
          end else begin
            next_st.fetch.kind = st.fetch.kind + gsr_pkg::FK_STEP;
          end
        end
      end
      // Hold the acknowledge until the queue writer takes it
      GSR_ACK: begin
        if (ack_ready_i) begin
          next_st.ack_valid = 1'b0;
          next_st.irq_set[st.cur_group] = 1'b1;
          next_st.phase     = GSR_IDLE;
        end
      end
      default: begin
        next_st.phase = GSR_IDLE;
      end
    endcase

    // Software may set the port map directly
    if (wr.valid && wr.addr == gsr_pkg::OFS_PORT_MAP) begin
      next_st.port_map = wr.data[1:0];
    end

    // Chip reset clears requests, ports, channels and the port map in the next cycle, far inside two line clocks,
    // and aborts any run so no acknowledge is produced for it or anything in flight
    if (chip_rst) begin
      next_st.pending     = '0;
      next_st.phase       = GSR_IDLE;
      next_st.fetch_valid = 1'b0;
      next_st.ack_valid   = 1'b0;
      next_st.port_map    = 2'h0;
      next_st.port_tx     = '0;
      next_st.port_rx     = '0;
      next_st.act_tx      = '0;
      next_st.act_rx      = '0;
      next_st.iq_rewind   = 1'b1;
      next_st.irq_set     = '0;
      next_st.irq_set[gsr_pkg::CHIP_IRQ_BIT] = 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from state
  assign fetch_valid_o       = st.fetch_valid;
  assign fetch_o             = st.fetch;
  assign ack_valid_o         = st.ack_valid;
  assign ack_o               = st.ack;
  assign port_to_group_map_o = st.port_map;
  assign port_en_tx_o        = st.port_tx;
  assign port_en_rx_o        = st.port_rx;
  assign chan_act_tx_o       = st.act_tx;
  assign chan_act_rx_o       = st.act_rx;
  assign iq_rewind_o         = st.iq_rewind;
endmodule

// ### dv/gsr_decoder_checker.sv
// Checker on the ports of the service request decoder
`timescale 1ns/1ps
module gsr_decoder_checker (
  // Clock, reset and bus
  input wire logic            clk_i, rstn_i, psel_i, penable_i, pwrite_i, pready_o,
  input wire logic [7:0]      paddr_i,
  input wire logic [31:0]     pwdata_i,
  // Fetch and acknowledge
  input wire logic            fetch_valid_o, fetch_done_i, ack_valid_o, ack_ready_i, iq_rewind_o,
  input gsr_pkg::gsr_fetch_t  fetch_o,
  input gsr_pkg::gsr_ack_t    ack_o,
  // Device state
  input wire logic [1:0]      port_to_group_map_o,
  input wire logic [7:0]      port_en_tx_o, port_en_rx_o,
  input wire logic [255:0]    chan_act_tx_o
);
  // Command write completes at this edge
  logic cw, cwc;
  assign cw  = psel_i && penable_i && pready_o && pwrite_i && (paddr_i < 8'h20) && (paddr_i[1:0] == 2'h0);
  assign cwc = cw && (pwdata_i[12:8] == 5'h01);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  a_pready_once: assert property (psel_i && penable_i && !pready_o |=> pready_o ##1 !pready_o)
    else $error("bus answer is not a single cycle");
  a_chip_clear: assert property (cwc |-> ##[1:2] (port_en_tx_o == 0 && port_en_rx_o == 0 &&
    chan_act_tx_o == 0 && port_to_group_map_o == 0)) else $error("chip reset left state");
  a_chip_rewind: assert property (cwc |-> ##[1:2] iq_rewind_o)
    else $error("chip reset without queue rewind");
  a_chip_noack: assert property (cwc |=> ##1 !ack_valid_o [*4])
    else $error("chip reset was acknowledged");
  a_ack_hold: assert property (ack_valid_o && !ack_ready_i && !cwc |=> ack_valid_o && $stable(ack_o))
    else $error("acknowledge dropped before taken");
  a_fetch_hold: assert property (fetch_valid_o && !fetch_done_i && !cwc |=> fetch_valid_o && $stable(fetch_o))
    else $error("fetch request dropped early");
  a_cmd_ack: assert property (cw && !cwc |-> ##[2:300] ack_valid_o)
    else $error("request never acknowledged");
  a_grp_reset: assert property (ack_valid_o && ack_o.code == 5'h02 |-> !port_en_tx_o[ack_o.group] &&
    !port_en_rx_o[ack_o.group] && chan_act_tx_o[ack_o.group*32 +: 32] == 0) else $error("group reset left state");
  // Main scenarios reached
  c_ack: cover property (ack_valid_o && ack_ready_i);
  c_rew: cover property (iq_rewind_o);
  c_port: cover property (fetch_done_i && fetch_o.kind == gsr_pkg::FK_PORTCFG);
endmodule
bind gsr_decoder gsr_decoder_checker u_chk (.clk_i, .rstn_i, .psel_i, .penable_i, .pwrite_i, .pready_o,
  .paddr_i, .pwdata_i, .fetch_valid_o, .fetch_done_i, .ack_valid_o, .ack_ready_i, .iq_rewind_o, .fetch_o,
  .ack_o, .port_to_group_map_o, .port_en_tx_o, .port_en_rx_o, .chan_act_tx_o);

// ### dv/gsr_dma_model.sv
// Descriptor fetch engine and queue writer standing beside the decoder
`timescale 1ns/1ps
module gsr_dma_model (
  input  wire logic clk_i, rstn_i, slow_i, fetch_valid_i,
  output logic      fetch_done_o, ack_ready_o
);
  logic [2:0] cnt;  // Cycles spent on the current fetch
  // Slow mode stretches fetches and holds ack_ready_o low every other cycle
  always_ff @(posedge clk_i) begin
    if (!rstn_i || !fetch_valid_i || fetch_done_o) begin
      cnt          <= 3'h0;
      fetch_done_o <= 1'b0;
    end else begin
      cnt          <= cnt + 3'h1;
      fetch_done_o <= (cnt == (slow_i ? 3'h4 : 3'h0));
    end
    ack_ready_o <= rstn_i && (!slow_i || !ack_ready_o);
  end
endmodule

// ### dv/gsr_decoder_tb.sv
// Self-checking bench for the service request decoder
`timescale 1ns/1ps
module gsr_decoder_tb;
  logic clk_i = 0, rstn_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0, slow = 0, rew = 0, err;
  logic [7:0] paddr_i = 0, seen = 0;
  logic [31:0] pwdata_i = 0, prdata_o, r;
  logic pready_o, pslverr_o, fetch_valid_o, fetch_done_i, ack_valid_o, ack_ready_i, iq_rewind_o, irq_o;
  gsr_pkg::gsr_fetch_t fetch_o;
  gsr_pkg::gsr_ack_t ack_o, la;
  logic [3:0] lk = 4'h0;  // Kind of the last finished fetch
  logic [1:0] port_to_group_map_o;
  logic [7:0] port_en_tx_o, port_en_rx_o;
  logic [255:0] chan_act_tx_o, chan_act_rx_o;
  int fails = 0, cmp_count = 0, ack_cnt = 0, n, k, fc = 0;
  logic [4:0] cl [11] = '{5'h0A, 5'h00, 5'h03, 5'h0B, 5'h10, 5'h11, 5'h12, 5'h13, 5'h14, 5'h15, 5'h09};
  always #5 clk_i = ~clk_i;
  gsr_decoder u_dut (.*);
  gsr_dma_model u_dma (.clk_i, .rstn_i, .slow_i(slow), .fetch_valid_i(fetch_valid_o),
    .fetch_done_o(fetch_done_i), .ack_ready_o(ack_ready_i));
  // Records every acknowledge the queue writer takes
  always @(posedge clk_i) begin
    if (ack_valid_o && ack_ready_i) begin
      ack_cnt++;
      seen[ack_o.group] = 1'b1;
      la = ack_o;
    end
    if (iq_rewind_o) rew = 1'b1;
    if (fetch_valid_o && fetch_done_i) begin
      fc++;
      lk = fetch_o.kind;
    end
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel_i <= 1; pwrite_i <= w; paddr_i <= a; pwdata_i <= d;
    @(posedge clk_i) penable_i <= 1;
    @(posedge clk_i);
    while (!pready_o) @(posedge clk_i);
    r = prdata_o; err = pslverr_o; psel_i <= 0; penable_i <= 0;
    // Idle edge, so a following call never reassigns psel_i in this time step
    @(posedge clk_i);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("Error t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // One request, host waits for its acknowledge before going on
  task automatic req(input int g, input logic [4:0] c, input logic d, input logic [4:0] ch);
    n = ack_cnt; k = 0; fc = 0;
    apb(1, 8'(g * 4), {19'h0, c, d, 2'b0, ch});
    while (ack_cnt == n && k < 300) begin @(posedge clk_i); k++; end
    if (k == 300) fails++;
    chk({18'h0, la}, {18'h0, 3'(g), c, d, ch});
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge clk_i);
    fails++;
    test_done;
  end
  initial begin
    repeat (12) @(posedge clk_i);
    rstn_i <= 1;
    @(posedge clk_i);
    apb(0, 8'h20, 0); chk(r, 0);
    apb(0, 8'h40, 0); chk({31'h0, err}, 1);
    apb(1, 8'h28, 32'h1FF); apb(1, 8'h2C, 2); apb(0, 8'h2C, 0); chk(r, 2);
    req(0, 5'h04, 0, 0); chk({31'h0, rew}, 1);
    chk({fc[27:0], lk}, {28'h2, gsr_pkg::FK_IQ});
    slow <= 1;
    for (int g = 0; g < 8; g++) for (int d = 0; d < 2; d++) req(g, 5'h05, d[0], 0);
    slow <= 0;
    chk({fc[27:0], lk}, {28'h7, gsr_pkg::FK_PORTCFG});
    chk({port_en_tx_o, port_en_rx_o}, 16'hFFFF);
    req(3, 5'h08, 0, 5); chk({31'h0, chan_act_tx_o[101]}, 1);
    chk({fc[27:0], lk}, {28'h1, gsr_pkg::FK_HEAD});
    foreach (cl[i]) req(3, cl[i], 0, 5);
    chk({31'h0, chan_act_tx_o[101]}, 0); chk({port_en_tx_o, port_en_rx_o}, 16'hFFFF);
    req(4, 5'h02, 0, 0); chk({port_en_tx_o[5:4], port_en_rx_o[4]}, 3'b100);
    req(1, 5'h08, 1, 7); chk({31'h0, chan_act_rx_o[39]}, 1);
    seen = 0;
    for (int g = 0; g < 8; g++) apb(1, 8'(g * 4), 0);
    k = 0;
    while (seen != 8'hFF && k < 300) begin @(posedge clk_i); k++; end
    chk(seen, 8'hFF);
    apb(0, 8'h20, 0); chk(r, 32'hFF); chk({31'h0, irq_o}, 1);
    apb(1, 8'h24, 32'h1FF); apb(0, 8'h20, 0); chk(r, 0);
    @(posedge clk_i); chk({31'h0, irq_o}, 0);
    n = ack_cnt;
    apb(1, 8'h08, 32'h100);
    repeat (2) @(posedge clk_i);
    chk({port_en_tx_o, port_en_rx_o, 6'h0, port_to_group_map_o}, 0);
    chk({31'h0, |{chan_act_tx_o, chan_act_rx_o}}, 0);
    repeat (10) @(posedge clk_i);
    chk(ack_cnt, n);
    apb(0, 8'h20, 0); chk(r, 32'h100);
    test_done;
  end
endmodule
